// ### hw/sas_pkg.sv
// Constants shared by the slot access switch
package sas_pkg;
	// Register bus geometry
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam int NREG = 4;
	// Register addresses
	localparam logic [3:0] ADR_DATA0 = 4'h0;
	localparam logic [3:0] ADR_SEL0 = 4'h4;
	localparam logic [3:0] ADR_PAIR1 = 4'h8;
	localparam logic [3:0] ADR_PAIR2 = 4'h9;
	localparam logic [3:0] ADR_STATUS = 4'hA;
	localparam logic [3:0] ADR_MASK = 4'hB;
	localparam logic [3:0] ADR_ACK = 4'hC;
	// Slot and port select fields
	localparam int SEL_LINE_BIT = 7;
	localparam int SLOT_W = 5;
	// Pair control fields
	localparam int PC_IN_EN0 = 0;
	localparam int PC_IN_EN1 = 1;
	localparam int PC_OUT_EN0 = 2;
	localparam int PC_OUT_EN1 = 3;
	localparam int PC_SWAP = 4;
	localparam int PC_ARB_MON = 5;
	// Status and mask layout: transfer flags low nibble, overflow high nibble
	localparam int XFER_LSB = 0;
	localparam int OVF_LSB = 4;
	// Reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	// Frame geometry
	localparam logic [4:0] ARB_SLOT = 5'h0B;
	localparam logic [7:0] SLOT_BITS = 8'h08;
	localparam logic [7:0] DLY_LINE0 = 8'h02;
	localparam logic [7:0] DLY_LINE1 = 8'h01;
	localparam logic [2:0] LAST_BIT = 3'h7;
	// Synchronised pin indices
	localparam int PIN_FS = 0;
	localparam int PIN_CLK2X = 1;
	localparam int PIN_UP = 2;
	localparam int PIN_DN = 3;
endpackage

// ### hw/sas_top.sv
// Slot access switch: four host data registers on a time-slot serial bus
//
// Overview of operation
// R1: Four data registers in two pairs, each reaching one of 32 slots.
// R2: Each register owns a select register; slot field picks slot 0 to 31.
// R3: Line bit sends output to one line; input uses the other line.
// R4: Output slot and line always come from the register's own select.
// R5: Swap clear: input and output both from own select register.
// R6: Swap set: each register of a pair inputs via its partner's select.
// R7: Separate input and output enables per register in pair control.
// R8: Input disabled keeps the value, so it repeats on output.
// R9: Software assigns at most one input and one output per slot.
// R10: Looped slot is captured one frame and driven the next.
// R11: Shift completes same frame if b >= a+2, else next frame.
// R12: Loop and shift run alone; host may touch data between interrupts.
// R13: Software puts even registers on even slots, odd on odd, when monitoring.
// R14: Arbitration monitor enable makes register x0 capture slot 11.
// R15: Four transfer and four overflow interrupts, one pair per register.
// R16: Transfer event two bits after slot (line 0), one bit (line 1).
// R17: Own overflow only when own transfer enabled and unacknowledged.
// R18: Overflow with masked own transfer fires for other missed transfers.
// R19: No transfer enabled means no interrupt at all.
// R20: Overflow with own transfer enabled follows only its own.
// R21: Host acknowledges before the deadline ahead of the slot.
// R22: Acknowledged transfers raise no overflow.
// R23: Events set readable flags; request asserted only where mask enables. Here a flag is set only when its own mask bit is set.
//
// Implementation choices: the placing of the registers and strobed register access.
module sas_top
	import sas_pkg::*;
(
	// Clock and reset
	input logic clk,
	input logic srst,
	// Register port
	input logic [sas_pkg::ADDR_W-1:0] reg_addr,
	input logic [sas_pkg::DATA_W-1:0] reg_wdata,
	input logic reg_wr,
	input logic reg_rd,
	output logic [sas_pkg::DATA_W-1:0] reg_rdata,
	// Serial bus timing
	input logic frame_sync,
	input logic double_rate_clock,
	// Upstream line
	input logic upstream_line,
	output logic upstream_line_tx,
	output logic upstream_line_drive_en,
	// Downstream line
	input logic downstream_line,
	output logic downstream_line_tx,
	output logic downstream_line_drive_en,
	// Interrupt request
	output logic irq
);
	import sas_pkg::*;

	// Pin synchroniser, filter and edge state
	logic [3:0] s1_q, s1_d, s2_q, s2_d, s3_q, s3_d, f_q, f_d, fp_q, fp_d;
	// Frame timing
	logic [8:0] cnt_q, cnt_d;
	logic fs_pend_q, fs_pend_d, rise_q, rise_d;
	logic bclk_rise, bclk_fall, fs_rise, drive_ev, samp_ev;
	logic [7:0] bit_idx;
	logic [4:0] cur_slot;
	logic [2:0] cur_bit;
	// Host registers
	logic [7:0] data_q [NREG];
	logic [7:0] data_d [NREG];
	logic [7:0] sel_q [NREG];
	logic [7:0] sel_d [NREG];
	logic [7:0] pair_q [2];
	logic [7:0] pair_d [2];
	logic [7:0] stat_q, stat_d, mask_q, mask_d;
	logic [7:0] rdata_q, rdata_d;
	logic irq_q, irq_d;
	// Datapath state
	logic [7:0] cap_q [NREG];
	logic [7:0] cap_d [NREG];
	logic [7:0] osh_q [NREG];
	logic [7:0] osh_d [NREG];
	logic [3:0] pend_q, pend_d;
	logic up_tx_q, up_tx_d, up_en_q, up_en_d, dn_tx_q, dn_tx_d, dn_en_q, dn_en_d;
	// Per-register derived signals
	logic [4:0] in_slot [NREG];
	logic [4:0] out_slot [NREG];
	logic [7:0] xfer_pos [NREG];
	logic [7:0] ovf_pos [NREG];
	logic [3:0] in_dn, out_up, in_en, out_en, in_hit, out_hit, in_bit;
	logic [3:0] xfer_fire, ovf_chk, ovf_set, ack_wr;
	logic [3:0] xfer_en, ovf_en;

	// Three flops per pin; a change counts once stages two and three agree
	always_comb
	begin
		s1_d = {downstream_line, upstream_line, double_rate_clock, frame_sync};
		s2_d = s1_q;
		s3_d = s2_q;
		f_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & f_q);
		fp_d = f_q;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			s1_q <= 4'h0;
			s2_q <= 4'h0;
			s3_q <= 4'h0;
			f_q <= 4'h0;
			fp_q <= 4'h0;
		end
		else
		begin
			s1_q <= s1_d;
			s2_q <= s2_d;
			s3_q <= s3_d;
			f_q <= f_d;
			fp_q <= fp_d;
		end
	end

	// Edges of the filtered bus clock and frame sync
	assign bclk_rise = f_q[PIN_CLK2X] & ~fp_q[PIN_CLK2X];
	assign bclk_fall = ~f_q[PIN_CLK2X] & fp_q[PIN_CLK2X];
	assign fs_rise = f_q[PIN_FS] & ~fp_q[PIN_FS];
	// Drive at start of a bit's first half, sample at the second half's fall
	assign drive_ev = rise_q & ~cnt_q[0];
	assign samp_ev = bclk_fall & cnt_q[0];
	assign bit_idx = cnt_q[8:1];
	assign cur_slot = bit_idx[7:3];
	assign cur_bit = bit_idx[2:0];

	// Half-bit counter restarts on the first clock edge after frame sync
	always_comb
	begin
		cnt_d = cnt_q;
		fs_pend_d = fs_pend_q | fs_rise;
		rise_d = bclk_rise;
		if (bclk_rise)
		begin
			if (fs_pend_q || fs_rise)
				cnt_d = 9'h000;
			else
				cnt_d = cnt_q + 9'h001;
			fs_pend_d = 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			cnt_q <= 9'h000;
			fs_pend_q <= 1'b0;
			rise_q <= 1'b0;
		end
		else
		begin
			cnt_q <= cnt_d;
			fs_pend_q <= fs_pend_d;
			rise_q <= rise_d;
		end
	end

	assign xfer_en = mask_q[XFER_LSB +: 4];
	assign ovf_en = mask_q[OVF_LSB +: 4];

	// Per-register slot routing and interrupt positions
	for (genvar i = 0; i < NREG; i++)
	begin : g_ch
		localparam int P = i / 2;
		localparam int Y = i % 2;
		logic swap, arb;
		logic [7:0] in_sel;
		logic [7:0] dly;
		assign swap = pair_q[P][PC_SWAP];
		assign arb = pair_q[P][PC_ARB_MON] && (Y == 0);
		assign in_sel = swap ? sel_q[i ^ 1] : sel_q[i]; // R5 R6
		assign in_slot[i] = arb ? ARB_SLOT : in_sel[SLOT_W-1:0]; // R14
		assign in_dn[i] = in_sel[SEL_LINE_BIT]; // R3
		assign out_slot[i] = sel_q[i][SLOT_W-1:0]; // R2 R4
		assign out_up[i] = sel_q[i][SEL_LINE_BIT]; // R3 R4
		assign in_en[i] = pair_q[P][PC_IN_EN0 + Y]; // R7
		assign out_en[i] = pair_q[P][PC_OUT_EN0 + Y]; // R7
		assign in_hit[i] = samp_ev && in_en[i] && (cur_slot == in_slot[i]);
		assign out_hit[i] = drive_ev && out_en[i] && (cur_slot == out_slot[i]);
		assign in_bit[i] = in_dn[i] ? f_q[PIN_DN] : f_q[PIN_UP];
		assign dly = out_up[i] ? DLY_LINE1 : DLY_LINE0;
		// Positions wrap modulo the 256-bit frame on purpose
		assign xfer_pos[i] = {out_slot[i], 3'h0} + SLOT_BITS + dly; // R16
		assign ovf_pos[i] = {out_slot[i], 3'h0} - dly; // R21
		assign xfer_fire[i] = drive_ev && xfer_en[i] && (bit_idx == xfer_pos[i]); // R15 R19
		assign ovf_chk[i] = drive_ev && pend_q[i] && (bit_idx == ovf_pos[i]);
		// Own overflow when own transfer enabled, else any missed transfer
		assign ovf_set[i] = ovf_en[i] && (xfer_en[i] ? ovf_chk[i] : |ovf_chk); // R17 R18 R20
		assign ack_wr[i] = reg_wr && (reg_addr == ADR_ACK) && reg_wdata[i];
	end

	// Capture, output shifting and line drive
	always_comb
	begin
		up_tx_d = up_tx_q;
		up_en_d = up_en_q;
		dn_tx_d = dn_tx_q;
		dn_en_d = dn_en_q;
		if (drive_ev)
		begin
			up_en_d = 1'b0;
			up_tx_d = 1'b0;
			dn_en_d = 1'b0;
			dn_tx_d = 1'b0;
		end
		for (int i = 0; i < NREG; i++)
		begin
			cap_d[i] = cap_q[i];
			osh_d[i] = osh_q[i];
			data_d[i] = data_q[i];
			if (reg_wr && (reg_addr == ADR_DATA0 + 4'(i)))
				data_d[i] = reg_wdata;
			// Shift register grabs every sampled bit of the input slot
			if (in_hit[i])
			begin
				cap_d[i] = {cap_q[i][6:0], in_bit[i]};
				if (cur_bit == LAST_BIT)
					data_d[i] = {cap_q[i][6:0], in_bit[i]}; // R1 R8 R12
			end
			// Snapshot one slot ahead, so a byte caught in the slot just before is too late
			if (drive_ev && (bit_idx == {5'(out_slot[i] - 5'h01), 3'h0}))
				osh_d[i] = data_q[i]; // R10 R11
			if (out_hit[i])
			begin
				osh_d[i] = {osh_q[i][6:0], 1'b0};
				if (out_up[i])
				begin
					up_en_d = 1'b1;
					up_tx_d = up_tx_d | osh_q[i][7];
				end
				else
				begin
					dn_en_d = 1'b1;
					dn_tx_d = dn_tx_d | osh_q[i][7];
				end
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			for (int i = 0; i < NREG; i++)
			begin
				cap_q[i] <= RST_BYTE;
				osh_q[i] <= RST_BYTE;
				data_q[i] <= RST_BYTE;
			end
			up_tx_q <= 1'b0;
			up_en_q <= 1'b0;
			dn_tx_q <= 1'b0;
			dn_en_q <= 1'b0;
		end
		else
		begin
			cap_q <= cap_d;
			osh_q <= osh_d;
			data_q <= data_d;
			up_tx_q <= up_tx_d;
			up_en_q <= up_en_d;
			dn_tx_q <= dn_tx_d;
			dn_en_q <= dn_en_d;
		end
	end

	// Configuration, status and read port; hardware sets win over clears
	always_comb
	begin
		for (int i = 0; i < NREG; i++)
		begin
			sel_d[i] = sel_q[i];
			if (reg_wr && (reg_addr == ADR_SEL0 + 4'(i)))
				sel_d[i] = reg_wdata;
		end
		pair_d = pair_q;
		mask_d = mask_q;
		if (reg_wr && (reg_addr == ADR_PAIR1))
			pair_d[0] = reg_wdata;
		if (reg_wr && (reg_addr == ADR_PAIR2))
			pair_d[1] = reg_wdata;
		if (reg_wr && (reg_addr == ADR_MASK))
			mask_d = reg_wdata;
		stat_d = stat_q;
		if (reg_wr && (reg_addr == ADR_STATUS))
			stat_d = stat_q & ~reg_wdata;
		stat_d[XFER_LSB +: 4] = stat_d[XFER_LSB +: 4] | xfer_fire; // R15 R23
		stat_d[OVF_LSB +: 4] = stat_d[OVF_LSB +: 4] | ovf_set; // R15 R23
		// Pending ends on acknowledge or at its deadline check
		pend_d = (pend_q & ~ack_wr & ~ovf_chk) | xfer_fire; // R22
		irq_d = |(stat_q & mask_q); // R23
		rdata_d = 8'h00;
		if (reg_rd)
		begin
			case (reg_addr)
				ADR_PAIR1: rdata_d = pair_q[0];
				ADR_PAIR2: rdata_d = pair_q[1];
				ADR_STATUS: rdata_d = stat_q;
				ADR_MASK: rdata_d = mask_q;
				default:
				begin
					if (reg_addr < ADR_SEL0)
						rdata_d = data_q[reg_addr[1:0]];
					else if (reg_addr < ADR_PAIR1)
						rdata_d = sel_q[reg_addr[1:0]];
				end
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			for (int i = 0; i < NREG; i++)
				sel_q[i] <= RST_BYTE;
			pair_q[0] <= RST_BYTE;
			pair_q[1] <= RST_BYTE;
			stat_q <= RST_BYTE;
			mask_q <= RST_BYTE;
			pend_q <= 4'h0;
			irq_q <= 1'b0;
			rdata_q <= RST_BYTE;
		end
		else
		begin
			sel_q <= sel_d;
			pair_q <= pair_d;
			stat_q <= stat_d;
			mask_q <= mask_d;
			pend_q <= pend_d;
			irq_q <= irq_d;
			rdata_q <= rdata_d;
		end
	end

	// Outputs straight from flops
	assign reg_rdata = rdata_q;
	assign upstream_line_tx = up_tx_q;
	assign upstream_line_drive_en = up_en_q;
	assign downstream_line_tx = dn_tx_q;
	assign downstream_line_drive_en = dn_en_q;
	assign irq = irq_q;

	// Checks on routing, capture and interrupt behaviour
	sequence s_xfer0_fire;
		drive_ev && xfer_en[0] && (bit_idx == xfer_pos[0]);
	endsequence

	sequence s_missed0;
		drive_ev && pend_q[0] && (bit_idx == ovf_pos[0]);
	endsequence

	a_swap_input: assert property (@(posedge clk) disable iff (srst) // R6
		(pair_q[0][PC_SWAP] && !pair_q[0][PC_ARB_MON]) |-> (in_slot[0] == sel_q[1][4:0]))
		else $error("swapped input slot wrong");

	a_own_input: assert property (@(posedge clk) disable iff (srst) // R5
		!pair_q[0][PC_SWAP] |-> (in_slot[1] == sel_q[1][4:0] && in_dn[1] == sel_q[1][7]))
		else $error("unswapped input routing wrong");

	a_arb_monitor: assert property (@(posedge clk) disable iff (srst) // R14
		pair_q[1][PC_ARB_MON] |-> (in_slot[2] == ARB_SLOT))
		else $error("arbitration slot not selected");

	a_hold_value: assert property (@(posedge clk) disable iff (srst) // R8
		(!in_en[0] && !(reg_wr && reg_addr == ADR_DATA0)) |=> (data_q[0] == $past(data_q[0])))
		else $error("data changed with input disabled");

	a_capture_byte: assert property (@(posedge clk) disable iff (srst) // R7
		(in_hit[1] && cur_bit == LAST_BIT) |=> (data_q[1] == {$past(cap_q[1][6:0]), $past(in_bit[1])}))
		else $error("captured byte wrong");

	a_line_drive: assert property (@(posedge clk) disable iff (srst) // R3
		(out_hit[0] && out_up[0]) |=> (upstream_line_drive_en && !downstream_line_drive_en)
			or (upstream_line_drive_en && downstream_line_drive_en))
		else $error("upstream drive missing");

	// A mask write in the event cycle may legally drop the request, so it is excluded
	a_xfer_raise: assert property (@(posedge clk) disable iff (srst) // R16
		(s_xfer0_fire ##0 !(reg_wr && reg_addr == ADR_MASK))
			|=> (stat_q[XFER_LSB] && pend_q[0]) ##1 irq)
		else $error("transfer flag not raised");

	a_own_overflow: assert property (@(posedge clk) disable iff (srst) // R17
		(s_missed0 ##0 ovf_en[0] && xfer_en[0]) |=> stat_q[OVF_LSB])
		else $error("own overflow missing");

	a_other_overflow: assert property (@(posedge clk) disable iff (srst) // R18
		(s_missed0 ##0 ovf_en[1] && !xfer_en[1]) |=> stat_q[OVF_LSB + 1])
		else $error("foreign overflow missing");

	a_own_only: assert property (@(posedge clk) disable iff (srst) // R20
		(ovf_chk[1] && !ovf_chk[0] && xfer_en[0] && !stat_q[OVF_LSB]
			&& !(reg_wr && reg_addr == ADR_STATUS)) |=> !stat_q[OVF_LSB])
		else $error("overflow followed a foreign transfer");

	a_quiet_masked: assert property (@(posedge clk) disable iff (srst) // R19
		(xfer_en == 4'h0 && pend_q == 4'h0 && stat_q == 8'h00) |=> (stat_q == 8'h00))
		else $error("interrupt with no transfer enabled");

	a_ack_clears: assert property (@(posedge clk) disable iff (srst) // R22
		(ack_wr[0] && !xfer_fire[0]) |=> !pend_q[0])
		else $error("acknowledge did not clear pending");

	// Nothing pending means no overflow can appear, whatever the masks say
	a_acked_quiet: assert property (@(posedge clk) disable iff (srst) // R22
		(pend_q == 4'h0 && stat_q[OVF_LSB +: 4] == 4'h0) |=> (stat_q[OVF_LSB +: 4] == 4'h0))
		else $error("overflow raised with nothing pending");
endmodule

// ### verif/sas_bus_model.sv
// Far side of the serial bus: timing master plus the other slot users
module sas_bus_model
(
	// Bus timing
	output logic frame_sync,
	output logic clk2x,
	// Device side of both lines
	input logic up_tx,
	input logic up_en,
	input logic dn_tx,
	input logic dn_en,
	// Resolved line levels
	output logic up_wire,
	output logic dn_wire
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] up_src [32];
	logic [7:0] dn_src [32];
	logic [7:0] up_cap [32];
	logic [7:0] dn_cap [32];
	logic up_drv = 1'b1;
	logic dn_drv = 1'b1;
	logic [7:0] su;
	logic [7:0] sd;
	int nframe;
	// Device drive wins; idle slots read the model's own source bytes, FF unless set
	assign up_wire = up_en ? up_tx : up_drv;
	assign dn_wire = dn_en ? dn_tx : dn_drv;
	// Bits go out on the first rise and are sampled on the second fall
	initial
	begin
		frame_sync = 1'b0;
		clk2x = 1'b0;
		nframe = 0;
		foreach (up_src[i])
		begin
			up_src[i] = 8'hFF;
			dn_src[i] = 8'hFF;
		end
		#1000;
		forever
			for (int b = 0; b < 256; b++)
			begin
				up_drv = up_src[b / 8][7 - b % 8];
				dn_drv = dn_src[b / 8][7 - b % 8];
				frame_sync = (b == 0);
				clk2x = 1'b1;
				#100 clk2x = 1'b0;
				#100 clk2x = 1'b1;
				frame_sync = 1'b0;
				#100 clk2x = 1'b0;
				su = {su[6:0], up_wire};
				sd = {sd[6:0], dn_wire};
				if (b % 8 == 7)
				begin
					up_cap[b / 8] = su;
					dn_cap[b / 8] = sd;
				end
				nframe += (b == 255);
				#100;
			end
	end
endmodule

// ### verif/tb_slot_access_switch.sv
// Bench for the slot access switch: loop, hold, shift, monitor, pacing
module tb_slot_access_switch
	import sas_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk;
	logic srst;
	logic [ADDR_W-1:0] reg_addr;
	logic [DATA_W-1:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [DATA_W-1:0] reg_rdata;
	logic fs;
	logic clk2x;
	logic up_w;
	logic dn_w;
	logic up_tx;
	logic up_en;
	logic dn_tx;
	logic dn_en;
	logic irq;
	int errors = 0;
	int total_checks = 0;
	int seed = 90;
	// Shift cases, pair one then pair two in each round
	int sa [4] = '{4, 20, 9, 26};
	int sb [4] = '{6, 3, 10, 28};
	// Pacing cases: mask and acknowledge
	logic [7:0] mk [5] = '{8'h11, 8'h21, 8'h10, 8'h33, 8'h73};
	logic [7:0] ak [5] = '{8'h01, 8'h00, 8'h00, 8'h02, 8'h00};

	sas_top dut
	(
		.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.frame_sync(fs), .double_rate_clock(clk2x),
		.upstream_line(up_w), .upstream_line_tx(up_tx), .upstream_line_drive_en(up_en),
		.downstream_line(dn_w), .downstream_line_tx(dn_tx),
		.downstream_line_drive_en(dn_en), .irq(irq)
	);
	sas_bus_model m
	(
		.frame_sync(fs), .clk2x(clk2x), .up_tx(up_tx), .up_en(up_en),
		.dn_tx(dn_tx), .dn_en(dn_en), .up_wire(up_w), .dn_wire(dn_w)
	);

	// System clock
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	function automatic logic [7:0] rnd();
		int r;
		r = $random(seed);
		return r[7:0];
	endfunction

	// Status model: pending transfers feed own or, when own is masked, any overflow
	function automatic logic [7:0] exp_status(input logic [7:0] k, input logic [7:0] a);
		logic [3:0] pend;
		logic [3:0] ov;
		pend = k[3:0] & ~a[3:0];
		for (int j = 0; j < 4; j++)
			ov[j] = k[4 + j] & (k[j] ? pend[j] : |pend);
		return {ov, k[3:0]};
	endfunction

	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Strobes are raised one edge after entry so back-to-back calls never collide
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic chk_reg(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask

	// Wait for whole frames, bounded
	task automatic frames(input int n);
		int f;
		int k;
		f = m.nframe + n;
		k = 0;
		while (m.nframe < f && k < 5000 * n)
		begin
			@(posedge clk);
			k++;
		end
		if (k >= 5000 * n)
		begin
			errors++;
			final_report();
		end
	endtask

	initial
	begin
		logic [7:0] ov [2];
		logic [7:0] nv [2];
		logic [7:0] v;
		logic [7:0] e;
		int k;
		srst = 1'b1;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		repeat (20) @(posedge clk);
		srst <= 1'b0;
		// Reset values; acknowledge and unmapped places read zero
		for (int a = 0; a < 16; a++)
			chk_reg(4'(a), RST_BYTE);
		for (int i = 0; i < NREG; i++)
		begin
			v = rnd();
			wr(4'(i), v);
			chk_reg(4'(i), v);
		end
		$display("registers done");
		// Loop both ways and watch the arbitration slot
		frames(1);
		m.up_src[2] = rnd();
		m.up_src[11] = rnd();
		m.dn_src[6] = rnd();
		m.up_src[3] = rnd();
		wr(ADR_SEL0, 8'h02);
		wr(ADR_SEL0 + 4'h1, 8'h86);
		wr(ADR_SEL0 + 4'h2, 8'h08);
		wr(ADR_SEL0 + 4'h3, 8'h03);
		wr(ADR_PAIR1, 8'h0F);
		wr(ADR_PAIR2, 8'h23);
		frames(2);
		chk(m.dn_cap[2], m.up_src[2]);
		chk(m.up_cap[6], m.dn_src[6]);
		chk(m.dn_cap[3], 8'hFF);
		chk_reg(ADR_DATA0 + 4'h2, m.up_src[11]);
		chk_reg(ADR_DATA0 + 4'h3, m.up_src[3]);
		chk_reg(ADR_DATA0, m.up_src[2]);
		$display("loop done");
		// Input off: host byte repeats, fresh line data is ignored
		wr(ADR_PAIR1, 8'h0C);
		v = rnd();
		wr(ADR_DATA0, v);
		m.up_src[2] = ~v;
		frames(2);
		chk(m.dn_cap[2], v);
		$display("hold done");
		// Shift a to b through swapped pairs, two cases a round
		for (int r = 0; r < 2; r++)
		begin
			k = 2 * r;
			for (int p = 0; p < 2; p++)
			begin
				wr(ADR_SEL0 + 4'(2 * p), 8'(sa[k + p]));
				wr(ADR_SEL0 + 4'(2 * p + 1), 8'(sb[k + p]));
				wr(ADR_PAIR1 + 4'(p), 8'h1A);
				ov[p] = rnd();
				m.up_src[sa[k + p]] = ov[p];
			end
			frames(2);
			for (int p = 0; p < 2; p++)
			begin
				nv[p] = ~ov[p];
				m.up_src[sa[k + p]] = nv[p];
			end
			frames(1);
			for (int p = 0; p < 2; p++)
				chk(m.dn_cap[sb[k + p]], (sb[k + p] >= sa[k + p] + 2) ? nv[p] : ov[p]);
			frames(1);
			for (int p = 0; p < 2; p++)
				chk(m.dn_cap[sb[k + p]], nv[p]);
		end
		$display("shift done");
		// All registers on slot 10 so frame edges fall between event and deadline
		wr(ADR_PAIR1, 8'h00);
		wr(ADR_PAIR2, 8'h00);
		for (int i = 0; i < NREG; i++)
			wr(ADR_SEL0 + 4'(i), 8'h0A);
		for (int i = 0; i < 5; i++)
		begin
			wr(ADR_MASK, mk[i]);
			wr(ADR_ACK, 8'h0F);
			frames(1);
			wr(ADR_STATUS, 8'hFF);
			wr(ADR_ACK, ak[i]);
			frames(1);
			e = exp_status(mk[i], ak[i]);
			chk_reg(ADR_STATUS, e);
			chk({7'h0, irq}, {7'h0, |e});
		end
		$display("pacing done");
		final_report();
	end
endmodule
